// *** rtl/dtc_cnt_if.sv ***
/*
 * Carrier between the timer control and one counter unit.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface dtc_cnt_if #(parameter int W = 8);
    logic         tick;
    logic         clr;
    logic [W-1:0] cnt;
    logic         carry;
    modport unit (input tick, input clr, output cnt, output carry);
    modport ctl  (output tick, output clr, input cnt, input carry);
endinterface : dtc_cnt_if
`default_nettype wire

// *** rtl/dtc_pkg.sv ***
/*
 * Constants for the dual timer control block: register offsets,
 * field positions, reset values and clock source codes.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package dtc_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] OFF_CTL_A = 4'h0;
    localparam logic [3:0] OFF_CTL_B = 4'h4;
    localparam logic [3:0] OFF_CNT   = 4'h8;
    localparam logic [3:0] OFF_CMP   = 4'hC;

    // ************************************************************
    // Control fields
    // ************************************************************
    localparam int MODE_BIT = 7;
    localparam int CSEL_HI  = 6;
    localparam int CSEL_LO  = 4;
    localparam int CLR_BIT  = 3;
    localparam int EN_BIT   = 2;
    localparam int IE_BIT   = 1;

    localparam logic [7:0]  CTL_A_WMASK = 8'hF6;
    localparam logic [7:0]  CTL_B_WMASK = 8'h76;
    localparam logic [7:0]  CTL_RST     = 8'h00;
    localparam logic [15:0] CMP_RST     = 16'hFFFF;

    // ************************************************************
    // Clock source codes
    // ************************************************************
    localparam logic [2:0] SRC_DIV512 = 3'h0;
    localparam logic [2:0] SRC_DIV256 = 3'h1;
    localparam logic [2:0] SRC_DIV64  = 3'h2;
    localparam logic [2:0] SRC_DIV8   = 3'h3;
    localparam logic [2:0] SRC_SYS    = 3'h4;
    localparam logic [2:0] SRC_SUB    = 3'h5;
    localparam logic [2:0] SRC_EXT    = 3'h6;

    localparam int PRESC_W = 9;
endpackage : dtc_pkg

// *** rtl/dtc_top.sv ***
/*
 * Dual timer control: two 8-bit timers or one cascaded 16-bit timer,
 * with an Avalon-MM slave for the control, count and compare registers.
 * Assumes sub_clk and ext_clk are asynchronous pins, slow against clk.
 */
// Our own choices: the Avalon-MM slave port and the placing of the registers.
// Behaviour
// - Writing one to the first timer's clear bit zeroes its counter, writing zero leaves it alone.
// - The first timer advances on its selected source while its enable bit is one and holds otherwise.
// - In 8-bit mode the second timer stops when its enable bit is zero and counts when it is one, except with the external pin selected;
//   cascaded, it follows the first timer's carry.
// - Writing one to the second timer's clear bit zeroes its counter, writing zero has no effect.
// - The second timer's interrupt request leaves the block only while its interrupt enable is one.
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        sub_clk,
    input  wire logic        ext_clk,
    output logic             irq_a,
    output logic             irq_b
);
    // ************************************************************
    // Bus slave
    // ************************************************************
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0]  ctl_a_q;
    logic [7:0]  ctl_b_q;
    logic [15:0] cmp_q;

    wire wr_hit = write && !wait_q;
    wire wr_a   = wr_hit && (address == dtc_pkg::OFF_CTL_A) && byteenable[0];
    wire wr_b   = wr_hit && (address == dtc_pkg::OFF_CTL_B) && byteenable[0];
    wire wr_cmp = wr_hit && (address == dtc_pkg::OFF_CMP);

    // Clear bits act on write only and are never stored
    wire wr_a_clr = wr_a && writedata[dtc_pkg::CLR_BIT];
    wire wr_b_clr = wr_b && writedata[dtc_pkg::CLR_BIT];

    // Every access: waitrequest low on the cycle after the request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 1'b1;
        end else if (!wait_q) begin
            wait_q <= 1'b1;
        end else if (read || write) begin
            wait_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (read && wait_q) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_a_q <= dtc_pkg::CTL_RST;
            ctl_b_q <= dtc_pkg::CTL_RST;
        end else begin
            if (wr_a) begin
                ctl_a_q <= writedata[7:0] & dtc_pkg::CTL_A_WMASK;
            end
            if (wr_b) begin
                ctl_b_q <= writedata[7:0] & dtc_pkg::CTL_B_WMASK;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmp_q <= dtc_pkg::CMP_RST;
        end else if (wr_cmp) begin
            if (byteenable[0]) begin
                cmp_q[7:0] <= writedata[7:0];
            end
            if (byteenable[1]) begin
                cmp_q[15:8] <= writedata[15:8];
            end
        end
    end

    // ************************************************************
    // Clock sources
    // ************************************************************
    logic [dtc_pkg::PRESC_W-1:0] div_q;
    logic [2:0]                  sub_s_q;
    logic [2:0]                  ext_s_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + {{(dtc_pkg::PRESC_W-1){1'b0}}, 1'b1};
        end
    end

    // Two flops before use, third only for the edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sub_s_q <= 3'h0;
            ext_s_q <= 3'h0;
        end else begin
            sub_s_q <= {sub_s_q[1:0], sub_clk};
            ext_s_q <= {ext_s_q[1:0], ext_clk};
        end
    end

    wire sub_rise = sub_s_q[1] && !sub_s_q[2];
    wire ext_rise = ext_s_q[1] && !ext_s_q[2];

    function automatic logic src_tick(input logic [2:0] sel,
                                      input logic [dtc_pkg::PRESC_W-1:0] div,
                                      input logic sub_e,
                                      input logic ext_e,
                                      input logic ext_ok);
        logic t;
        t = 1'b0;
        case (sel)
            dtc_pkg::SRC_DIV512: t = &div[8:0];
            dtc_pkg::SRC_DIV256: t = &div[7:0];
            dtc_pkg::SRC_DIV64:  t = &div[5:0];
            dtc_pkg::SRC_DIV8:   t = &div[2:0];
            dtc_pkg::SRC_SYS:    t = 1'b1;
            dtc_pkg::SRC_SUB:    t = sub_e;
            dtc_pkg::SRC_EXT:    t = ext_e && ext_ok;
            default:             t = 1'b0;
        endcase
        return t;
    endfunction : src_tick

    // ************************************************************
    // Counters
    // ************************************************************
    dtc_cnt_if #(.W(8)) a_if ();
    dtc_cnt_if #(.W(8)) b_if ();

    dtc_unit #(.W(8)) u_a (.clk(clk), .nrst(nrst), .port_i(a_if.unit));
    dtc_unit #(.W(8)) u_b (.clk(clk), .nrst(nrst), .port_i(b_if.unit));

    wire mode16 = ctl_a_q[dtc_pkg::MODE_BIT];
    wire en_a   = ctl_a_q[dtc_pkg::EN_BIT];
    wire en_b   = ctl_b_q[dtc_pkg::EN_BIT];
    wire ie_a   = ctl_a_q[dtc_pkg::IE_BIT];
    wire ie_b   = ctl_b_q[dtc_pkg::IE_BIT];

    wire sel_a  = src_tick(ctl_a_q[dtc_pkg::CSEL_HI:dtc_pkg::CSEL_LO], div_q, sub_rise, ext_rise, 1'b1);
    wire sel_b  = src_tick(ctl_b_q[dtc_pkg::CSEL_HI:dtc_pkg::CSEL_LO], div_q, sub_rise, ext_rise, 1'b0);

    wire tick_a  = en_a && sel_a;
    wire tick_b8 = en_b && sel_b;

    // Compare match clears the counter, as an interval timer
    wire match_a8 = !mode16 && tick_a && (a_if.cnt == cmp_q[7:0]);
    wire match_b8 = !mode16 && tick_b8 && (b_if.cnt == cmp_q[15:8]);
    wire match16  = mode16 && tick_a && ({b_if.cnt, a_if.cnt} == cmp_q);

    assign a_if.tick = tick_a;
    assign a_if.clr  = wr_a_clr || match_a8 || match16;
    // Cascade: upper byte follows the lower byte's carry
    assign b_if.tick = mode16 ? a_if.carry : tick_b8;
    assign b_if.clr  = wr_b_clr || match_b8 || match16 || (mode16 && wr_a_clr);

    // ************************************************************
    // Interrupt requests and read mux
    // ************************************************************
    logic irq_a_q;
    logic irq_b_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else begin
            irq_a_q <= ie_a && (match_a8 || match16);
            irq_b_q <= ie_b && match_b8;
        end
    end

    always_comb begin
        case (address)
            dtc_pkg::OFF_CTL_A: rdata_d = {24'h000000, ctl_a_q};
            dtc_pkg::OFF_CTL_B: rdata_d = {24'h000000, ctl_b_q};
            dtc_pkg::OFF_CNT:   rdata_d = {16'h0000, b_if.cnt, a_if.cnt};
            dtc_pkg::OFF_CMP:   rdata_d = {16'h0000, cmp_q};
            default:            rdata_d = 32'h0000_0000;
        endcase
    end

    assign readdata    = rdata_q;
    assign waitrequest = wait_q;
    assign irq_a       = irq_a_q;
    assign irq_b       = irq_b_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_clear_a_zero: assert property (wr_a_clr |=> a_if.cnt == 8'h00)
        else $error("first counter not zero after clear write");
    a_hold_a_off: assert property (!en_a && !wr_a_clr |=> $stable(a_if.cnt))
        else $error("first counter moved while disabled");
    a_run_a_step: assert property (tick_a && !a_if.clr |=> a_if.cnt == $past(a_if.cnt) + 8'h01)
        else $error("first counter did not advance on tick");
    a_hold_b_off: assert property (!mode16 && !en_b && !b_if.clr |=> $stable(b_if.cnt))
        else $error("second counter moved while disabled");
    a_clear_b_zero: assert property (wr_b_clr |=> b_if.cnt == 8'h00)
        else $error("second counter not zero after clear write");
    a_irq_b_gate: assert property (irq_b_q |-> $past(ie_b) && $past(match_b8))
        else $error("second request without enable or match");
    a_irq_b_fire: assert property (ie_b && match_b8 |=> irq_b_q)
        else $error("enabled second match not forwarded");
    a_cascade_carry: assert property (mode16 && a_if.carry && !b_if.clr
                                      |=> b_if.cnt == $past(b_if.cnt) + 8'h01)
        else $error("upper byte missed the carry");
    a_split_b_idle: assert property (mode16 |=> !irq_b_q)
        else $error("second request in cascaded mode");

    c_match_a:   cover property (ie_a && match_a8 ##1 irq_a_q);
    c_match16:   cover property (match16);
    c_cascade:   cover property (mode16 && a_if.carry);
    c_clear_b:   cover property (wr_b_clr && tick_b8);
endmodule : dtc_top
`default_nettype wire

// *** rtl/dtc_unit.sv ***
/*
 * One up-counter of the dual timer: clears, advances on tick.
 * Assumes tick and clr are one-cycle enables on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dtc_unit #(
    parameter int W = 8
) (
    input  wire logic clk,
    input  wire logic nrst,
    dtc_cnt_if.unit   port_i
);
    logic [W-1:0] cnt_q;

    // Clear wins over a tick in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (port_i.clr) begin
            cnt_q <= '0;
        end else if (port_i.tick) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign port_i.cnt   = cnt_q;
    assign port_i.carry = port_i.tick && (cnt_q == {W{1'b1}});
endmodule : dtc_unit
`default_nettype wire

// *** verification/tb_dual_timer_control.sv ***
/*
 * Self-checking bench for the dual timer control block: reset values,
 * enable, hold, clear, interrupt gating and the cascaded 16-bit mode.
 * Assumes the Avalon-MM slave answers within a few cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timer_control;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        clk;
    logic        nrst;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        sub_clk;
    logic        ext_clk;
    logic        irq_a;
    logic        irq_b;
    logic [1:0]  irqv;
    logic [31:0] v;
    logic [31:0] w;
    logic [3:0]  off;
    int          errors;
    int          checks;
    int          gap;
    int          n;

    assign irqv = {irq_b, irq_a};

    dtc_top i_dut (
        .clk         (clk),
        .nrst        (nrst),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .sub_clk     (sub_clk),
        .ext_clk     (ext_clk),
        .irq_a       (irq_a),
        .irq_b       (irq_b)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk

    // Request held until waitrequest is sampled low
    task automatic bus(input logic is_wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rdata);
        int k;
        k = 0;
        @(posedge clk);
        address    <= adr;
        writedata  <= wd;
        byteenable <= 4'hF;
        write      <= is_wr;
        read       <= ~is_wr;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        rdata = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        if (k >= 50) begin
            chk(32'h0, 32'h1);
            tally_and_finish();
        end
    endtask : bus

    task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, adr, wd, d);
    endtask : wr

    task automatic rd(input logic [3:0] adr, output logic [31:0] d);
        bus(1'b0, adr, 32'h0, d);
    endtask : rd

    // Cycles between two interrupt pulses; 0 if none comes
    task automatic period(input int t, input int lim, output int g);
        int k;
        k = 0;
        g = 0;
        while (irqv[t] !== 1'b1 && k < lim) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        g = 1;
        while (irqv[t] !== 1'b1 && g < lim) begin
            @(posedge clk);
            g++;
        end
        if (g >= lim || k >= lim) g = 0;
    endtask : period

    // Rising edges on both pins, slow enough for the synchronisers
    task automatic pins(input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            sub_clk <= 1'b1;
            ext_clk <= 1'b1;
            repeat (4) @(posedge clk);
            sub_clk <= 1'b0;
            ext_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : pins

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        nrst = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
        sub_clk = 1'b0;
        ext_clk = 1'b0;
        errors = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(4'(i * 4), v);
            chk((i == 3) ? 32'h0000FFFF : 32'h0, v);
        end
        rd(4'h2, v);
        chk(32'h0, v);
        $display("test reset_values done");
        for (int t = 0; t < 2; t++) begin
            off = (t == 0) ? dtc_pkg::OFF_CTL_A : dtc_pkg::OFF_CTL_B;
            wr(dtc_pkg::OFF_CMP, 32'h0000FFFF);
            wr(off, 32'h00000044);
            repeat (20) @(posedge clk);
            wr(off, 32'h00000040);
            rd(dtc_pkg::OFF_CNT, v);
            chk(32'h1, {31'h0, ((v >> (8 * t)) & 32'hFF) != 32'h0});
            repeat (20) @(posedge clk);
            rd(dtc_pkg::OFF_CNT, w);
            chk(v, w);
            wr(off, 32'h00000048);
            rd(dtc_pkg::OFF_CNT, v);
            chk(32'h0, v);
            rd(off, v);
            chk(32'h00000040, v);
            // Match at 3: counter runs 0..3, one pulse every 4 cycles
            wr(dtc_pkg::OFF_CMP, 32'h00000303);
            wr(off, 32'h00000044);
            n = 0;
            repeat (40) begin
                @(posedge clk);
                if (irqv[t] === 1'b1) n++;
            end
            chk(32'h0, 32'(n));
            wr(off, 32'h00000046);
            period(t, 100, gap);
            chk(32'h4, 32'(gap));
            wr(off, 32'h00000008);
            $display("test timer_%0d done", t);
        end
        // Cascaded mode: upper byte advances on lower byte carry
        wr(dtc_pkg::OFF_CMP, 32'h0000FFFF);
        wr(dtc_pkg::OFF_CTL_A, 32'h000000C4);
        repeat (300) @(posedge clk);
        wr(dtc_pkg::OFF_CTL_A, 32'h00000080);
        rd(dtc_pkg::OFF_CNT, v);
        chk(32'h1, {31'h0, v[15:8] != 8'h00});
        wr(dtc_pkg::OFF_CTL_A, 32'h00000088);
        rd(dtc_pkg::OFF_CNT, v);
        chk(32'h0, v);
        wr(dtc_pkg::OFF_CMP, 32'h00000100);
        wr(dtc_pkg::OFF_CTL_A, 32'h000000C6);
        period(0, 600, gap);
        chk(32'h101, 32'(gap));
        $display("test cascaded done");
        // Prescaler taps: match at zero gives one pulse per source tick
        wr(dtc_pkg::OFF_CMP, 32'h00000000);
        for (int c = 0; c < 4; c++) begin
            wr(dtc_pkg::OFF_CTL_A, 32'h00000008);
            wr(dtc_pkg::OFF_CTL_A, 32'h00000006 | (32'(c) << 4));
            period(0, 1200, gap);
            chk((c == 0) ? 32'h200 : (c == 1) ? 32'h100 : (c == 2) ? 32'h40 : 32'h8, 32'(gap));
        end
        $display("test prescaler done");
        // Pin sources: the second timer has no external input
        wr(dtc_pkg::OFF_CMP, 32'h0000FFFF);
        wr(dtc_pkg::OFF_CTL_A, 32'h0000006C);
        wr(dtc_pkg::OFF_CTL_B, 32'h0000005C);
        pins(5);
        rd(dtc_pkg::OFF_CNT, v);
        chk(32'h00000505, v);
        wr(dtc_pkg::OFF_CTL_A, 32'h0000005C);
        wr(dtc_pkg::OFF_CTL_B, 32'h0000006C);
        pins(3);
        rd(dtc_pkg::OFF_CNT, v);
        chk(32'h00000003, v);
        $display("test sources done");
        tally_and_finish();
    end
endmodule : tb_dual_timer_control
`default_nettype wire
